//--- sps_port_control.sv
// Pin-side control of a pipelined synchronous burst SRAM port
// Behaviour
// R1: The active-low third chip select is sampled each enabled rising edge and joins the other two in selection; the code samples it only with adv_load_n low.
// R2: The active-low output enable acts without the clock, letting the data pins drive when low and float when high.
// R3: Data outputs stay floating during a write data cycle, the first clock after deselect, and while deselected.
// R4: Only edges seen with the active-low clock gate low advance any sampled input or state; the code clocks strap, scan and write buffer on every edge.
// R5: Raising the clock gate does not deselect; the current operation simply stays pending.
// R6: Incoming data on the data lines is captured into a data register on the rising clock edge.
// R7: A read drives the word at the address sampled on the previous rise, one pipeline stage later.
// R8: Parity lines act as data lines, each parity lane written only with its own byte-write select.
// R9: The burst-order strap picks interleaved order when high and linear order when low.
// R10: The strap reads as high when left open and is expected to stay constant in operation.
// R11: Serial scan output changes on the falling edge of the scan clock.
// R12: Serial scan input is sampled on the rising edge of the scan clock.
// R13: The active-low first chip select is sampled on the rising edge and joins selection.
// R14: The active-high second chip select is sampled on the rising edge and joins selection.
`timescale 1ns/1ps
module sps_port_control
  import sps_pkg::*;
#(
  parameter int DW = DATA_WIDTH,
  parameter int NL = LANES,
  parameter int AW = ADDR_WIDTH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Controller pins
  input wire logic chip_select_a_n,
  input wire logic chip_select_b,
  input wire logic chip_select_c_n,
  input wire logic clock_gate_n,
  input wire logic write_enable_n,
  input wire logic adv_load_n,
  input wire logic [AW-1:0] address,
  input wire logic [NL-1:0] byte_write_select_n,
  input wire logic output_enable_n,
  input wire logic burst_mode,
  // Data and parity pins
  input wire logic [DW-1:0] data_in,
  output logic [DW-1:0] data_out,
  input wire logic [NL-1:0] parity_lines_in,
  output logic [NL-1:0] parity_lines_out,
  output logic data_oe,
  // Scan serial pins
  input wire logic tck,
  input wire logic tdi,
  output logic tdo,
  // Scan user side
  input wire logic scan_out_bit,
  output logic scan_in_bit,
  output logic scan_in_strobe,
  // Memory core read port
  output logic core_read,
  output logic [AW-1:0] core_address,
  input wire logic [DW+NL-1:0] core_read_data,
  // Memory core write port
  output logic core_write_valid,
  input wire logic core_write_ready,
  output logic [AW-1:0] core_write_address,
  output logic [NL-1:0] core_write_lanes,
  output logic [DW+NL-1:0] core_write_data
);
  localparam int WW = AW + NL + NL + DW;

  sps_stream_if #(.WIDTH(WW)) fill_if ();
  sps_stream_if #(.WIDTH(WW)) drain_if ();

  // ************************************************
  // Address stage
  // ************************************************
  sps_op_type op, next_op;
  logic [AW-1:0] addr, next_addr;
  logic [NL-1:0] lanes, next_lanes;
  logic [BURST_BITS-1:0] burst_base, next_burst_base;
  logic [BURST_BITS-1:0] burst_count, next_burst_count;
  logic next_core_read;
  logic selected;
  logic advance;

  // ************************************************
  // Data stage
  // ************************************************
  logic [DW-1:0] read_word, next_read_word;
  logic [NL-1:0] read_parity, next_read_parity;
  logic drive_window, next_drive_window;
  logic push_valid, next_push_valid;
  logic [WW-1:0] push_word, next_push_word;

  // ************************************************
  // Strap and scan synchronisers
  // ************************************************
  logic [SYNC_STAGES-1:0] mode_sync;
  logic [SYNC_STAGES-1:0] tck_sync;
  logic [SYNC_STAGES-1:0] tdi_sync;
  logic tck_last;
  logic interleaved;
  logic tck_rise, tck_fall;
  logic next_tdo, next_scan_in_bit, next_scan_in_strobe;

  assign selected = !chip_select_a_n && chip_select_b && !chip_select_c_n;  // [R1] [R13] [R14]
  // Only a write whose word would overwrite one still waiting at a full buffer holds the pipe
  // Limitation: the controller sees no wait, so a long core stall can drop its write data
  assign advance = !clock_gate_n && !(op == OP_WRITE && push_valid && !fill_if.ready);  // [R4] [R5]
  assign interleaved = mode_sync[SYNC_STAGES-1];  // [R9]
  assign next_core_read = (next_op == OP_READ);  // [R7]

  always_comb begin
    next_op = op;
    next_addr = addr;
    next_lanes = lanes;
    next_burst_base = burst_base;
    next_burst_count = burst_count;
    if (advance) begin
      if (!adv_load_n) begin
        if (selected) begin
          next_op = write_enable_n ? OP_READ : OP_WRITE;
          next_addr = address;
          next_lanes = ~byte_write_select_n;
          next_burst_base = address[BURST_BITS-1:0];
          next_burst_count = BURST_START;
        end else begin
          next_op = OP_DESELECT;
        end
      end else if (op == OP_READ || op == OP_WRITE) begin
        next_burst_count = burst_count + BURST_STEP;
        next_addr[BURST_BITS-1:0] = interleaved ? (burst_base ^ next_burst_count)
                                                : (burst_base + next_burst_count);
        next_lanes = ~byte_write_select_n;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      op <= OP_IDLE;
      core_read <= 1'b0;
      addr <= '0;
      lanes <= '0;
      burst_base <= BURST_START;
      burst_count <= BURST_START;
    end else begin
      op <= next_op;
      core_read <= next_core_read;
      addr <= next_addr;
      lanes <= next_lanes;
      burst_base <= next_burst_base;
      burst_count <= next_burst_count;
    end
  end

  always_comb begin
    next_read_word = read_word;
    next_read_parity = read_parity;
    next_drive_window = drive_window;
    next_push_word = push_word;
    next_push_valid = push_valid && !fill_if.ready;
    if (!clock_gate_n) begin
      // Window opens only for a read's data cycle; deselect and write cycles close it
      next_drive_window = (op == OP_READ);  // [R3] [R7]
    end
    if (advance) begin
      if (op == OP_READ) begin
        next_read_word = core_read_data[DW-1:0];  // [R7]
        next_read_parity = core_read_data[DW+NL-1:DW];  // [R8]
      end
      if (op == OP_WRITE) begin
        next_push_word = {addr, lanes, parity_lines_in, data_in};  // [R6] [R8]
        next_push_valid = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      read_word <= '0;
      read_parity <= '0;
      drive_window <= 1'b0;
      push_valid <= 1'b0;
      push_word <= '0;
    end else begin
      read_word <= next_read_word;
      read_parity <= next_read_parity;
      drive_window <= next_drive_window;
      push_valid <= next_push_valid;
      push_word <= next_push_word;
    end
  end

  assign fill_if.valid = push_valid;
  assign fill_if.data = push_word;
  assign drain_if.ready = core_write_ready;

  sps_word_buffer #(.WIDTH(WW), .DEPTH(BUFFER_DEPTH)) write_buffer (
    .clk(clk),
    .reset(reset),
    .fill(fill_if),
    .drain(drain_if)
  );

  assign data_out = read_word;
  assign parity_lines_out = read_parity;
  // Output enable is combinational by design: the pin gates the drivers without a clock
  assign data_oe = drive_window && !output_enable_n;  // [R2] [R3]
  assign core_address = addr;
  assign core_write_valid = drain_if.valid;
  assign core_write_address = drain_if.data[WW-1:WW-AW];
  assign core_write_lanes = drain_if.data[DW+2*NL-1:DW+NL];  // [R8]
  assign core_write_data = drain_if.data[DW+NL-1:0];

  // ************************************************
  // Scan clock edges, seen through two flip-flops
  // ************************************************
  assign tck_rise = tck_sync[SYNC_STAGES-1] && !tck_last;
  assign tck_fall = !tck_sync[SYNC_STAGES-1] && tck_last;

  always_comb begin
    next_tdo = tdo;
    next_scan_in_bit = scan_in_bit;
    next_scan_in_strobe = tck_rise;
    if (tck_fall) begin
      next_tdo = scan_out_bit;  // [R11]
    end
    if (tck_rise) begin
      next_scan_in_bit = tdi_sync[SYNC_STAGES-1];  // [R12]
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      // Open strap reads high until the synchroniser fills
      mode_sync <= {SYNC_STAGES{MODE_RESET}};  // [R10]
      tck_sync <= '0;
      tdi_sync <= '0;
      tck_last <= 1'b0;
      tdo <= 1'b0;
      scan_in_bit <= 1'b0;
      scan_in_strobe <= 1'b0;
    end else begin
      mode_sync <= {mode_sync[SYNC_STAGES-2:0], burst_mode};
      tck_sync <= {tck_sync[SYNC_STAGES-2:0], tck};
      tdi_sync <= {tdi_sync[SYNC_STAGES-2:0], tdi};
      tck_last <= tck_sync[SYNC_STAGES-1];
      tdo <= next_tdo;
      scan_in_bit <= next_scan_in_bit;
      scan_in_strobe <= next_scan_in_strobe;
    end
  end
endmodule

//--- sps_pkg.sv
// Shared constants and types for the synchronous SRAM port control block
package sps_pkg;
  localparam int DATA_WIDTH = 32;
  localparam int LANES = 4;
  localparam int ADDR_WIDTH = 18;
  localparam int BURST_BITS = 2;
  localparam int BUFFER_DEPTH = 2;
  localparam int SYNC_STAGES = 2;
  localparam logic MODE_RESET = 1'h1;
  localparam logic [BURST_BITS-1:0] BURST_START = 2'h0;
  localparam logic [BURST_BITS-1:0] BURST_STEP = 2'h1;

  typedef enum logic [1:0] {
    OP_IDLE = 2'b00,
    OP_READ = 2'b01,
    OP_WRITE = 2'b10,
    OP_DESELECT = 2'b11
  } sps_op_type;
endpackage

//--- sps_stream_if.sv
// Valid/ready word carrier between the port control and its write buffer
`timescale 1ns/1ps
interface sps_stream_if #(parameter int WIDTH = 8);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;
  modport source (output valid, output data, input ready);
  modport sink (input valid, input data, output ready);
endinterface

//--- sps_word_buffer.sv
// Small valid/ready buffer with registered outputs on both sides
`timescale 1ns/1ps
module sps_word_buffer
  import sps_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = BUFFER_DEPTH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Filling side
  sps_stream_if.sink fill,
  // Draining side
  sps_stream_if.source drain
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW:0] FULL_COUNT = (PW + 1)'(DEPTH);
  localparam logic [PW-1:0] LAST_SLOT = PW'(DEPTH - 1);

  logic [WIDTH-1:0] store [DEPTH];
  logic [PW-1:0] head, tail, next_head, next_tail;
  logic [PW:0] count, next_count;
  logic push, pop;
  logic not_full, next_not_full, not_empty, next_not_empty;

  assign push = fill.valid && fill.ready;
  assign pop = drain.valid && drain.ready;
  assign fill.ready = not_full;
  assign drain.valid = not_empty;
  assign drain.data = store[head];

  always_comb begin
    next_head = head;
    next_tail = tail;
    next_count = count;
    if (push) begin
      next_tail = (tail == LAST_SLOT) ? '0 : tail + 1'b1;
    end
    if (pop) begin
      next_head = (head == LAST_SLOT) ? '0 : head + 1'b1;
    end
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
    next_not_full = (next_count != FULL_COUNT);
    next_not_empty = (next_count != '0);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      head <= '0;
      tail <= '0;
      count <= '0;
      not_full <= 1'b1;
      not_empty <= 1'b0;
    end else begin
      head <= next_head;
      tail <= next_tail;
      count <= next_count;
      not_full <= next_not_full;
      not_empty <= next_not_empty;
    end
  end

  // Storage needs no reset; count guards every read
  always_ff @(posedge clk) begin
    if (push) begin
      store[tail] <= fill.data;
    end
  end
endmodule

//--- sps_port_control_asserts.sv
// Pin-side checks for the SRAM port control
`timescale 1ns/1ps
module sps_port_control_asserts
  import sps_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Controller pins
  input wire logic chip_select_a_n,
  input wire logic chip_select_b,
  input wire logic chip_select_c_n,
  input wire logic clock_gate_n,
  input wire logic write_enable_n,
  input wire logic adv_load_n,
  input wire logic output_enable_n,
  input wire logic [ADDR_WIDTH-1:0] address,
  // Data, scan and core side
  input wire logic [DATA_WIDTH-1:0] data_out,
  input wire logic data_oe,
  input wire logic tck,
  input wire logic tdo,
  input wire logic scan_out_bit,
  input wire logic scan_in_strobe,
  input wire logic core_read,
  input wire logic core_write_valid,
  input wire logic [ADDR_WIDTH-1:0] core_address,
  input wire logic [DATA_WIDTH+LANES-1:0] core_read_data
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  logic sel;
  logic [DATA_WIDTH-1:0] core_word;
  assign sel = !chip_select_a_n && chip_select_b && !chip_select_c_n;
  assign core_word = core_read_data[DATA_WIDTH-1:0];
  sequence ld_rd;
    sel && !adv_load_n && write_enable_n && !clock_gate_n;
  endsequence
  // Write load followed by its enabled data edge
  sequence ld_wr_data;
    sel && !adv_load_n && !write_enable_n && !clock_gate_n ##1 !clock_gate_n;
  endsequence
  chk_oe_async: assert property (output_enable_n |-> !data_oe)
    else $error("oe high yet driving");
  chk_mask_float: assert property (!clock_gate_n && !core_read |=> !data_oe)
    else $error("driving after non-read");
  chk_read_pipe: assert property (ld_rd |=> core_read && core_address == $past(address))
    else $error("read not launched");
  chk_desel_idle: assert property (!sel && !adv_load_n && !clock_gate_n |=> !core_read)
    else $error("read while deselected");
  chk_read_data: assert property (core_read && !clock_gate_n |=> data_out == $past(core_word))
    else $error("read word wrong");
  chk_gate_hold: assert property (clock_gate_n |=> $stable(data_out) && $stable(core_read))
    else $error("gated edge advanced");
  chk_write_push: assert property (ld_wr_data |-> ##[1:4] core_write_valid)
    else $error("write word missing");
  chk_scan_in: assert property ($rose(tck) |-> ##[1:5] scan_in_strobe)
    else $error("scan input not sampled");
  chk_scan_out: assert property ($fell(tck) ##0 scan_out_bit [*6] |-> tdo)
    else $error("scan output not shifted");
endmodule

bind sps_port_control sps_port_control_asserts sps_port_control_asserts_inst (.*);

//--- sps_core_model.sv
// Behavioural memory core on the far side of the port control
`timescale 1ns/1ps
module sps_core_model
  import sps_pkg::*;
(
  // Clock and stall request
  input wire logic clk,
  input wire logic stall,
  // Read port
  input wire logic core_read,
  input wire logic [ADDR_WIDTH-1:0] core_address,
  output logic [DATA_WIDTH+LANES-1:0] core_read_data,
  // Write port
  input wire logic core_write_valid,
  input wire logic [ADDR_WIDTH-1:0] core_write_address,
  input wire logic [LANES-1:0] core_write_lanes,
  input wire logic [DATA_WIDTH+LANES-1:0] core_write_data,
  output logic core_write_ready
);
  logic [DATA_WIDTH+LANES-1:0] mem [16];
  initial begin
    for (int i = 0; i < 16; i++) begin
      mem[i] = {4'(i), {8{4'(i)}}};
    end
  end
  // Idle port shows the inverse so stale data never passes for a read
  assign core_read_data = core_read ? mem[core_address[3:0]] : ~mem[core_address[3:0]];
  assign core_write_ready = !stall;
  always @(posedge clk) begin
    for (int i = 0; i < LANES; i++) begin
      if (core_write_valid && core_write_ready && core_write_lanes[i]) begin
        mem[core_write_address[3:0]][8*i +: 8] <= core_write_data[8*i +: 8];
        mem[core_write_address[3:0]][DATA_WIDTH+i] <= core_write_data[DATA_WIDTH+i];
      end
    end
  end
endmodule

//--- sync_sram_port_control_tb_top.sv
// Self-checking bench for the SRAM port control
`timescale 1ns/1ps
module sync_sram_port_control_tb_top
  import sps_pkg::*;
;
  logic clk, reset, chip_select_a_n, chip_select_b, chip_select_c_n, clock_gate_n, write_enable_n;
  logic adv_load_n, output_enable_n, burst_mode, tck, tdi, tdo, scan_out_bit, scan_in_bit, scan_in_strobe;
  logic data_oe, core_read, core_write_valid, core_write_ready, stall;
  logic [ADDR_WIDTH-1:0] address, core_address, core_write_address;
  logic [LANES-1:0] byte_write_select_n, parity_lines_in, parity_lines_out, core_write_lanes;
  logic [DATA_WIDTH-1:0] data_in, data_out;
  logic [DATA_WIDTH+LANES-1:0] core_read_data, core_write_data;
  int n_fail = 0;
  int n_tests = 0;
  int cycles = 0;
  sps_port_control sps_port_control_inst (.*);
  sps_core_model sps_core_model_inst (.*);
  initial begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      n_fail++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [35:0] exp, input logic [35:0] got);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Ctl is {write_enable_n, adv_load_n, clock_gate_n}; inputs move 2 ns after the edge
  task automatic cyc(input logic [2:0] cs, input logic [2:0] ctl, input logic [17:0] a, input logic [3:0] bw);
    {chip_select_a_n, chip_select_b, chip_select_c_n} = cs;
    {write_enable_n, adv_load_n, clock_gate_n} = ctl;
    address = a;
    byte_write_select_n = bw;
    @(posedge clk);
    #2;
  endtask
  task automatic idle(input int n);
    repeat (n) cyc(3'h0, 3'h4, 18'h0, 4'hf);
  endtask
  task automatic do_reset();
    reset = 1'h1;
    repeat (16) @(posedge clk);
    #2;
    reset = 1'h0;
    idle(3);
  endtask
  // Writes pile up against a stalled core, then are read back
  task automatic t_rw();
    stall = 1'h1;
    {parity_lines_in, data_in} = 36'h5_cafe_0123;
    cyc(3'h2, 3'h0, 18'h5, 4'h0);
    cyc(3'h2, 3'h0, 18'h7, 4'ha);
    chk("oe in write data", 36'h0, data_oe);
    {parity_lines_in, data_in} = 36'ha_5566_7788;
    idle(4);
    chk("write stands", 36'h1, core_write_valid);
    chk("write address", 36'h5, core_write_address);
    chk("write lanes", 36'hf, core_write_lanes);
    chk("write data", 36'h5_cafe_0123, core_write_data);
    stall = 1'h0;
    idle(4);
    cyc(3'h2, 3'h4, 18'h5, 4'hf);
    cyc(3'h2, 3'h4, 18'h7, 4'hf);
    chk("read full word", 36'h5_cafe_0123, {parity_lines_out, data_out});
    chk("oe on read", 36'h1, data_oe);
    idle(1);
    chk("read lane mix", 36'h2_7766_7788, {parity_lines_out, data_out});
    output_enable_n = 1'h1;
    #1;
    chk("oe released", 36'h0, data_oe);
    @(posedge clk);
    #2;
    output_enable_n = 1'h0;
    idle(1);
    chk("oe deselected", 36'h0, data_oe);
    cyc(3'h2, 3'h4, 18'h6, 4'hf);
    chk("oe after deselect", 36'h0, data_oe);
    idle(1);
  endtask
  task automatic t_gate();
    cyc(3'h2, 3'h4, 18'h3, 4'hf);
    repeat (3) cyc(3'h0, 3'h5, 18'h0, 4'hf);
    chk("gated data", 36'h6666_6666, data_out);
    chk("op pending", 36'h1, core_read);
    idle(1);
    chk("released data", 36'h3333_3333, data_out);
  endtask
  task automatic t_select();
    logic [2:0] cs [3] = '{3'h6, 3'h0, 3'h3};
    foreach (cs[i]) begin
      cyc(cs[i], 3'h4, 18'h1, 4'hf);
      chk("one select off", 36'h0, core_read);
    end
  endtask
  task automatic t_scan();
    {tdi, scan_out_bit, tck} = 3'h7;
    repeat (8) begin
      @(posedge clk);
      #2;
      if (scan_in_strobe === 1'h1) break;
    end
    chk("scan strobe", 36'h1, scan_in_strobe);
    chk("scan in", 36'h1, scan_in_bit);
    chk("tdo before fall", 36'h0, tdo);
    tck = 1'h0;
    idle(6);
    chk("tdo after fall", 36'h1, tdo);
  endtask
  task automatic t_burst(input logic mode, input logic [7:0] seq);
    burst_mode = mode;
    do_reset();
    cyc(3'h2, 3'h4, 18'h1, 4'hf);
    for (int i = 1; i < 4; i++) begin
      cyc(3'h2, 3'h6, 18'h0, 4'hf);
      chk("burst address", seq[2*i +: 2], core_address);
    end
    idle(1);
  endtask
  initial begin
    {chip_select_a_n, chip_select_b, chip_select_c_n, write_enable_n, adv_load_n, clock_gate_n} = 6'h2c;
    {address, byte_write_select_n, output_enable_n, burst_mode} = 24'hf1;
    {data_in, parity_lines_in, tck, tdi, scan_out_bit, stall} = 40'h0;
    do_reset();
    t_rw();
    t_gate();
    t_select();
    t_scan();
    t_burst(1'h1, 8'hb1);
    t_burst(1'h0, 8'h39);
    end_sim();
  end
endmodule
